// ### src/aoc_pkg.sv
package aoc_pkg;

  localparam int AOC_DW = 32;
  localparam int AOC_AW = 6;

  // register byte offsets
  localparam logic [5:0] AOC_CTRL_OFS = 6'h00;
  localparam logic [5:0] AOC_REQ_OFS = 6'h04;
  localparam logic [5:0] AOC_LOLIM_OFS = 6'h08;
  localparam logic [5:0] AOC_HILIM_OFS = 6'h0c;
  localparam logic [5:0] AOC_RAMP_OFS = 6'h10;
  localparam logic [5:0] AOC_CAL_OFS = 6'h14;
  localparam logic [5:0] AOC_FLAGS_OFS = 6'h18;
  localparam logic [5:0] AOC_OUT_OFS = 6'h1c;
  localparam logic [5:0] AOC_ISTAT_OFS = 6'h20;
  localparam logic [5:0] AOC_IMASK_OFS = 6'h24;

  // control register bits
  localparam int AOC_C_SUPP = 0;
  localparam int AOC_C_CALCON = 1;
  localparam int AOC_C_CALIB = 2;
  localparam int AOC_C_LOCLR = 3;
  localparam int AOC_C_HICLR = 4;
  localparam int AOC_C_RPCLR = 5;
  localparam int AOC_C_LATCH = 6;
  localparam int AOC_C_HOLD = 7;
  localparam int AOC_NCTRL = 8;

  // calibration reference report bits
  localparam int AOC_K_LOREF = 0;
  localparam int AOC_K_HIREF = 1;

  // status flag bits, shared by flags, irq status and irq mask
  localparam int AOC_F_HOLD = 0;
  localparam int AOC_F_NAN = 1;
  localparam int AOC_F_UNDER = 2;
  localparam int AOC_F_OVER = 3;
  localparam int AOC_F_LO = 4;
  localparam int AOC_F_HI = 5;
  localparam int AOC_F_RAMP = 6;
  localparam int AOC_F_CALF = 7;
  localparam int AOC_F_CALING = 8;
  localparam int AOC_F_LOREF = 9;
  localparam int AOC_NFLAG = 10;

  // reset values; limit values are signed microamps
  localparam logic [7:0] AOC_CTRL_RST = 8'h00;
  localparam logic [31:0] AOC_LOLIM_RST = 32'h0000_0fa0;
  localparam logic [31:0] AOC_HILIM_RST = 32'h0000_4e20;
  localparam logic [31:0] AOC_RAMP_RST = 32'h0000_0000;
  localparam logic [9:0] AOC_MASK_RST = 10'h000;
  localparam logic [31:0] AOC_NAN_CODE = 32'h8000_0000;

  localparam int AOC_FS_UA = 16000;
  localparam int AOC_UNDER_UA = 3600;
  localparam int AOC_OVER_UA = 21000;
  localparam int AOC_HOLD_PERMIL = 1;

  typedef enum logic [0:0] {
    AOC_CAL_IDLE = 1'b0,
    AOC_CAL_RUN = 1'b1
  } aoc_cal_e;

  typedef struct packed {
    logic [AOC_NCTRL-1:0] ctrl;
    logic signed [31:0] req;
    logic signed [31:0] lolim;
    logic signed [31:0] hilim;
    logic [31:0] ramp;
    logic signed [31:0] outv;
    logic [AOC_NFLAG-1:0] fl;
    logic [AOC_NFLAG-1:0] stat;
    logic [AOC_NFLAG-1:0] mask;
    aoc_cal_e cal;
    logic lo_ok;
    logic hi_ok;
    logic wait_req;
    logic [31:0] rdata;
    logic irq;
  } aoc_state_s;

  localparam aoc_state_s AOC_STATE_RST = '{
    ctrl: AOC_CTRL_RST,
    req: 32'h0000_0000,
    lolim: AOC_LOLIM_RST,
    hilim: AOC_HILIM_RST,
    ramp: AOC_RAMP_RST,
    outv: 32'h0000_0000,
    fl: 10'h000,
    stat: 10'h000,
    mask: AOC_MASK_RST,
    cal: AOC_CAL_IDLE,
    lo_ok: 1'b0,
    hi_ok: 1'b0,
    wait_req: 1'b1,
    rdata: 32'h0000_0000,
    irq: 1'b0
  };

endpackage : aoc_pkg

// ### src/aoc_channel.sv
// Overview of operation
// - hold flag set while output kept; released by value within 0.1% FS
// - invalid-float flag follows whether the latest written value was numeric
// - below-range flag set when output is at or below 3.6 mA
// - above-range flag set when output is at or above 21.0 mA
// - low alarm raised below low limit, held until value above it
// - output clamped to low limit unless held; suppress blocks the low alarm
// - high alarm raised above high limit, held until value below it
// - output clamped to high limit unless held; suppress blocks the high alarm
// - slew alarm raised when a step exceeds the configured maximum step
// - calibration failed flag set on failed calibration; reset only clears
// - calibrating flag high exactly while calibration is running
// - low reference valid flag set once host reports good low reference
// - low reference valid flag reads zero unless calibration data enabled
// - a 0-to-1 step of the low clear command unlatches the low alarm
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

module aoc_channel
  import aoc_pkg::*;
#(
  parameter int FULL_SCALE = AOC_FS_UA,
  parameter int UNDER_TH = AOC_UNDER_UA,
  parameter int OVER_TH = AOC_OVER_UA
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [AOC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [AOC_DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [AOC_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output logic [31:0] out_value_o,
  output logic [AOC_NFLAG-1:0] flags_o
);

  localparam logic [32:0] TOL =
    33'(FULL_SCALE * AOC_HOLD_PERMIL / 1000);
  localparam logic signed [31:0] UNDER_V = 32'(UNDER_TH);
  localparam logic signed [31:0] OVER_V = 32'(OVER_TH);

  // a tolerance of zero would release a held channel only on an exact match
  if (FULL_SCALE < 1000 || UNDER_TH >= OVER_TH) begin : g_chk
    $error("aoc_channel: unusable scale or range thresholds");
  end

  function automatic logic [31:0] aoc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : aoc_merge

  function automatic logic [32:0] aoc_absdiff(
    input logic signed [31:0] a,
    input logic signed [31:0] b
  );
    logic signed [32:0] d;
    d = {a[31], a} - {b[31], b};
    return d[32] ? 33'(-d) : 33'(d);
  endfunction : aoc_absdiff

  function automatic logic signed [31:0] aoc_clamp(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : aoc_clamp

  aoc_state_s st_ff;
  aoc_state_s nxt;

  logic wr_go;
  logic rd_go;
  logic req_go;
  logic cal_go;
  logic [31:0] wv;
  logic [AOC_NCTRL-1:0] rise;
  logic signed [31:0] newv;
  logic step_bad;
  logic [31:0] mrg;

  always_comb begin
    nxt = st_ff;
    wr_go = avs_write_i && !st_ff.wait_req;
    rd_go = avs_read_i && !st_ff.wait_req;
    wv = avs_writedata_i;
    rise = '0;
    req_go = 1'b0;
    cal_go = 1'b0;
    newv = '0;
    step_bad = 1'b0;
    mrg = '0;

    // one wait state: read data are captured as waitrequest drops
    nxt.wait_req = 1'b1;
    if ((avs_read_i || avs_write_i) && st_ff.wait_req) begin
      nxt.wait_req = 1'b0;
      case (avs_address_i)
        AOC_CTRL_OFS: nxt.rdata = 32'(st_ff.ctrl);
        AOC_REQ_OFS: nxt.rdata = st_ff.req;
        AOC_LOLIM_OFS: nxt.rdata = st_ff.lolim;
        AOC_HILIM_OFS: nxt.rdata = st_ff.hilim;
        AOC_RAMP_OFS: nxt.rdata = st_ff.ramp;
        AOC_CAL_OFS: nxt.rdata = {30'h0, st_ff.hi_ok, st_ff.lo_ok};
        AOC_FLAGS_OFS: nxt.rdata = 32'(st_ff.fl);
        AOC_OUT_OFS: nxt.rdata = st_ff.outv;
        AOC_ISTAT_OFS: nxt.rdata = 32'(st_ff.stat);
        AOC_IMASK_OFS: nxt.rdata = 32'(st_ff.mask);
        default: nxt.rdata = 32'h0000_0000;
      endcase
    end

    if (wr_go) begin
      case (avs_address_i)
        AOC_CTRL_OFS: begin
          mrg = aoc_merge(32'(st_ff.ctrl), wv, avs_byteenable_i);
          nxt.ctrl = mrg[AOC_NCTRL-1:0];
          rise = nxt.ctrl & ~st_ff.ctrl;
        end
        AOC_REQ_OFS: begin
          req_go = 1'b1;
          newv = aoc_merge(st_ff.req, wv, avs_byteenable_i);
        end
        AOC_LOLIM_OFS: begin
          nxt.lolim = aoc_merge(st_ff.lolim, wv, avs_byteenable_i);
        end
        AOC_HILIM_OFS: begin
          nxt.hilim = aoc_merge(st_ff.hilim, wv, avs_byteenable_i);
        end
        AOC_RAMP_OFS: begin
          nxt.ramp = aoc_merge(st_ff.ramp, wv, avs_byteenable_i);
        end
        AOC_CAL_OFS: cal_go = avs_byteenable_i[0];
        AOC_IMASK_OFS: begin
          mrg = aoc_merge(32'(st_ff.mask), wv, avs_byteenable_i);
          nxt.mask = mrg[AOC_NFLAG-1:0];
        end
        default: ;
      endcase
    end

    if (rise[AOC_C_HOLD]) begin
      nxt.fl[AOC_F_HOLD] = 1'b1;
    end

    if (req_go) begin
      if (newv == AOC_NAN_CODE) begin
        // the invalid value is dropped; output keeps its last value
        nxt.fl[AOC_F_NAN] = 1'b1;
      end else begin
        nxt.fl[AOC_F_NAN] = 1'b0;
        step_bad = st_ff.ramp != 32'h0 &&
                   aoc_absdiff(newv, st_ff.req) > {1'b0, st_ff.ramp};
        if (st_ff.fl[AOC_F_HOLD] &&
            aoc_absdiff(newv, st_ff.outv) <= TOL) begin
          nxt.fl[AOC_F_HOLD] = 1'b0;
        end
        nxt.req = newv;
      end
    end

    // a held channel keeps its output; otherwise it tracks the request
    if (!nxt.fl[AOC_F_HOLD]) begin
      nxt.outv = aoc_clamp(nxt.req, nxt.lolim, nxt.hilim);
    end

    // ranges follow the driven value and clear by themselves
    nxt.fl[AOC_F_UNDER] = nxt.outv <= UNDER_V;
    nxt.fl[AOC_F_OVER] = nxt.outv >= OVER_V;

    // limit alarms: the clear is applied first so that a set wins
    if (rise[AOC_C_LOCLR] ||
        (!nxt.ctrl[AOC_C_LATCH] && nxt.req > nxt.lolim)) begin
      nxt.fl[AOC_F_LO] = 1'b0;
    end
    if (nxt.req < nxt.lolim && !nxt.ctrl[AOC_C_SUPP]) begin
      nxt.fl[AOC_F_LO] = 1'b1;
    end
    if (rise[AOC_C_HICLR] ||
        (!nxt.ctrl[AOC_C_LATCH] && nxt.req < nxt.hilim)) begin
      nxt.fl[AOC_F_HI] = 1'b0;
    end
    if (nxt.req > nxt.hilim && !nxt.ctrl[AOC_C_SUPP]) begin
      nxt.fl[AOC_F_HI] = 1'b1;
    end

    if (rise[AOC_C_RPCLR] ||
        (req_go && !step_bad && !nxt.ctrl[AOC_C_LATCH])) begin
      nxt.fl[AOC_F_RAMP] = 1'b0;
    end
    if (step_bad && !nxt.ctrl[AOC_C_SUPP]) begin
      nxt.fl[AOC_F_RAMP] = 1'b1;
    end

    case (st_ff.cal)
      AOC_CAL_IDLE: begin
        if (nxt.ctrl[AOC_C_CALIB]) begin
          nxt.cal = AOC_CAL_RUN;
          nxt.lo_ok = 1'b0;
          nxt.hi_ok = 1'b0;
        end
      end
      AOC_CAL_RUN: begin
        if (cal_go) begin
          nxt.lo_ok = st_ff.lo_ok | wv[AOC_K_LOREF];
          nxt.hi_ok = st_ff.hi_ok | wv[AOC_K_HIREF];
        end
        // dropping calibrate early is the host's fault, seen as failure
        if (!nxt.ctrl[AOC_C_CALIB]) begin
          nxt.cal = AOC_CAL_IDLE;
          if (!(nxt.lo_ok && nxt.hi_ok)) begin
            nxt.fl[AOC_F_CALF] = 1'b1;
          end
        end
      end
      default: nxt.cal = AOC_CAL_IDLE;
    endcase
    nxt.fl[AOC_F_CALING] = nxt.cal == AOC_CAL_RUN;
    nxt.fl[AOC_F_LOREF] = nxt.lo_ok && nxt.ctrl[AOC_C_CALCON];

    // a status read clears only the bits it returned, so new events stay
    for (int i = 0; i < AOC_NFLAG; i++) begin
      if (rd_go && avs_address_i == AOC_ISTAT_OFS && st_ff.rdata[i]) begin
        nxt.stat[i] = 1'b0;
      end
      if (nxt.fl[i] && !st_ff.fl[i]) begin
        nxt.stat[i] = 1'b1;
      end
    end
    nxt.irq = |(nxt.stat & nxt.mask);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_ff <= AOC_STATE_RST;
    end else begin
      st_ff <= nxt;
    end
  end

  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = st_ff.wait_req;
  assign irq_o = st_ff.irq;
  assign out_value_o = st_ff.outv;
  assign flags_o = st_ff.fl;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_req_new;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_bus_ack;
    s_req_new |=> s_ack;
  endproperty

  AST_BUS_ACK: assert property (p_bus_ack)
    else $error("waitrequest did not drop for exactly one cycle");

  AST_HOLD_KEEP: assert property (
    flags_o[AOC_F_HOLD] ##1 flags_o[AOC_F_HOLD] |-> $stable(out_value_o))
    else $error("output moved while channel held");

  AST_NAN_SET: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i == AOC_REQ_OFS &&
    avs_writedata_i == AOC_NAN_CODE && avs_byteenable_i == 4'hf
    |=> flags_o[AOC_F_NAN] && $stable(out_value_o))
    else $error("invalid value not flagged or not dropped");

  // the first edge after reset still shows the reset state, not a result
  AST_UNDER: assert property (
    $past(rstn_i) |->
    flags_o[AOC_F_UNDER] == ($signed(out_value_o) <= UNDER_V))
    else $error("below-range flag disagrees with output");

  AST_OVER: assert property (
    $past(rstn_i) |->
    flags_o[AOC_F_OVER] == ($signed(out_value_o) >= OVER_V))
    else $error("above-range flag disagrees with output");

  AST_CLAMP: assert property (
    $past(rstn_i) && !flags_o[AOC_F_HOLD] && st_ff.lolim <= st_ff.hilim
    |-> $signed(out_value_o) >= st_ff.lolim &&
        $signed(out_value_o) <= st_ff.hilim)
    else $error("output outside limits");

  AST_LO_SUPP: assert property (
    $rose(flags_o[AOC_F_LO]) |-> !st_ff.ctrl[AOC_C_SUPP])
    else $error("low alarm raised while suppressed");

  AST_HI_SET: assert property (
    st_ff.req > st_ff.hilim && !st_ff.ctrl[AOC_C_SUPP]
    |-> flags_o[AOC_F_HI])
    else $error("high alarm missing above limit");

  AST_LO_SET: assert property (
    $past(rstn_i) && st_ff.req < st_ff.lolim && !st_ff.ctrl[AOC_C_SUPP]
    |-> flags_o[AOC_F_LO])
    else $error("low alarm missing below limit");

  AST_HI_SUPP: assert property (
    $rose(flags_o[AOC_F_HI]) |-> !st_ff.ctrl[AOC_C_SUPP])
    else $error("high alarm raised while suppressed");

  AST_CALING: assert property (
    $rose(st_ff.ctrl[AOC_C_CALIB]) |-> flags_o[AOC_F_CALING])
    else $error("calibrating flag missing after calibrate");

  AST_CALF_STICKY: assert property (
    flags_o[AOC_F_CALF] |=> flags_o[AOC_F_CALF])
    else $error("calibration failure flag cleared without reset");

  AST_LOREF_CONN: assert property (
    !st_ff.ctrl[AOC_C_CALCON] |-> !flags_o[AOC_F_LOREF])
    else $error("low reference flag shown without calibration data");

  AST_IRQ: assert property (
    (|(st_ff.stat & st_ff.mask)) == irq_o)
    else $error("interrupt output disagrees with status and mask");

endmodule : aoc_channel

// ### tb/aoc_host.sv
`timescale 1ns/1ps

// host side of the cyclic exchange, reduced to single register bus cycles
module aoc_host
  import aoc_pkg::*;
(
  input wire logic clk_i,
  output logic [AOC_AW-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [AOC_DW-1:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [AOC_DW-1:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  initial begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = '0;
    avs_byteenable_o = 4'h0;
  end

  // no own limit on the wait: only the bench timeout ends a stall
  task automatic xfer(input logic [5:0] a, input logic wr_en,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_address_o <= a;
    avs_read_o <= ~wr_en;
    avs_write_o <= wr_en;
    avs_writedata_o <= d;
    avs_byteenable_o <= 4'hf;
    forever begin
      @(posedge clk_i);
      if (avs_waitrequest_i === 1'b0) break;
    end
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0000_0000, q);
  endtask : rd
endmodule : aoc_host

// ### tb/tb_aoc_channel.sv
`timescale 1ns/1ps

module tb_aoc_channel
  import aoc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [AOC_AW-1:0] adr;
  logic rd_s, wr_s, wq, irq_o;
  logic [31:0] wd, rdat, out_value_o;
  logic [3:0] be;
  logic [AOC_NFLAG-1:0] flags_o;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  aoc_channel u_aoc_channel (.clk_i(clk_i), .rstn_i(rstn_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .irq_o(irq_o), .out_value_o(out_value_o),
    .flags_o(flags_o));

  aoc_host u_aoc_host (.clk_i(clk_i), .avs_address_o(adr),
    .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wd),
    .avs_byteenable_o(be), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wq));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // a few hundred clock cycles are expected; far more means a stall
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_aoc_host.rd(a, q);
    chk(q, exp);
  endtask : rc

  task automatic wc(input logic [5:0] a, input logic [31:0] v);
    u_aoc_host.wr(a, v);
    @(negedge clk_i);
  endtask : wc

  task automatic rq(input logic [31:0] v, input logic [9:0] ef,
                    input logic [31:0] eo);
    wc(AOC_REQ_OFS, v);
    chk(32'(flags_o), 32'(ef));
    chk(out_value_o, eo);
  endtask : rq

  task automatic do_reset;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  initial begin
    do_reset();
    rc(AOC_CTRL_OFS, 32'h0000_0000);
    rc(AOC_LOLIM_OFS, 32'h0000_0fa0);
    rc(AOC_HILIM_OFS, 32'h0000_4e20);
    rc(AOC_RAMP_OFS, 32'h0000_0000);
    rc(AOC_IMASK_OFS, 32'h0000_0000);
    rc(6'h28, 32'h0000_0000);
    // the zero request after reset lies below the reset low limit
    rc(AOC_FLAGS_OFS, 32'h0000_0010);
    rq(32'd12000, 10'h000, 32'd12000);
    rq(32'd2000, 10'h010, 32'd4000);
    rq(32'd4000, 10'h010, 32'd4000);
    rq(32'd4001, 10'h000, 32'd4001);
    rq(32'd25000, 10'h020, 32'd20000);
    rq(32'd20000, 10'h020, 32'd20000);
    rq(32'd19999, 10'h000, 32'd19999);
    wc(AOC_LOLIM_OFS, 32'd0);
    wc(AOC_HILIM_OFS, 32'd30000);
    rq(32'd3600, 10'h004, 32'd3600);
    rq(32'd3601, 10'h000, 32'd3601);
    rq(32'd0, 10'h004, 32'd0);
    rq(32'd21000, 10'h008, 32'd21000);
    rq(32'd20999, 10'h000, 32'd20999);
    wc(AOC_CTRL_OFS, 32'h0000_0001);
    rq(-32'sd100, 10'h004, 32'd0);
    rq(32'd40000, 10'h008, 32'd30000);
    rq(32'd12000, 10'h000, 32'd12000);
    wc(AOC_CTRL_OFS, 32'h0000_0000);
    rq(AOC_NAN_CODE, 10'h002, 32'd12000);
    rq(32'd12000, 10'h000, 32'd12000);
    wc(AOC_RAMP_OFS, 32'd1000);
    rq(32'd13000, 10'h000, 32'd13000);
    rq(32'd14001, 10'h040, 32'd14001);
    rq(32'd14500, 10'h000, 32'd14500);
    wc(AOC_RAMP_OFS, 32'd0);
    wc(AOC_CTRL_OFS, 32'h0000_0080);
    chk(32'(flags_o), 32'h0000_0001);
    rq(32'd15000, 10'h001, 32'd14500);
    rq(32'd14517, 10'h001, 32'd14500);
    rq(32'd14516, 10'h000, 32'd14516);
    rc(AOC_OUT_OFS, 32'd14516);
    wc(AOC_CTRL_OFS, 32'h0000_0040);
    rq(-32'sd500, 10'h014, 32'd0);
    rq(32'd12000, 10'h010, 32'd12000);
    wc(AOC_CTRL_OFS, 32'h0000_0048);
    chk(32'(flags_o), 32'h0000_0000);
    rq(32'd40000, 10'h028, 32'd30000);
    rq(32'd12000, 10'h020, 32'd12000);
    wc(AOC_CTRL_OFS, 32'h0000_0058);
    chk(32'(flags_o), 32'h0000_0000);
    wc(AOC_RAMP_OFS, 32'd1000);
    rq(32'd14000, 10'h040, 32'd14000);
    rq(32'd14500, 10'h040, 32'd14500);
    wc(AOC_CTRL_OFS, 32'h0000_0078);
    chk(32'(flags_o), 32'h0000_0000);
    wc(AOC_RAMP_OFS, 32'd0);
    rq(32'd12000, 10'h000, 32'd12000);
    wc(AOC_CTRL_OFS, 32'h0000_0000);
    rc(AOC_ISTAT_OFS, 32'h0000_007f);
    @(negedge clk_i);
    chk(32'(irq_o), 32'h0000_0000);
    wc(AOC_IMASK_OFS, 32'h0000_0010);
    rq(AOC_NAN_CODE, 10'h002, 32'd12000);
    chk(32'(irq_o), 32'h0000_0000);
    wc(AOC_IMASK_OFS, 32'h0000_0002);
    chk(32'(irq_o), 32'h0000_0001);
    rc(AOC_ISTAT_OFS, 32'h0000_0002);
    @(negedge clk_i);
    chk(32'(irq_o), 32'h0000_0000);
    rq(32'd12000, 10'h000, 32'd12000);
    // calibrate first stays high until both references are reported, then drops after the low one only
    wc(AOC_CTRL_OFS, 32'h0000_0006);
    chk(32'(flags_o), 32'h0000_0100);
    wc(AOC_CAL_OFS, 32'h0000_0001);
    chk(32'(flags_o[9]), 32'h0000_0001);
    wc(AOC_CAL_OFS, 32'h0000_0002);
    wc(AOC_CTRL_OFS, 32'h0000_0002);
    chk(32'(flags_o[8:7]), 32'h0000_0000);
    wc(AOC_CTRL_OFS, 32'h0000_0004);
    wc(AOC_CAL_OFS, 32'h0000_0001);
    chk(32'(flags_o[9:8]), 32'h0000_0001);
    wc(AOC_CTRL_OFS, 32'h0000_0000);
    chk(32'(flags_o[8:7]), 32'h0000_0001);
    wc(AOC_CTRL_OFS, 32'h0000_0006);
    wc(AOC_CAL_OFS, 32'h0000_0003);
    wc(AOC_CTRL_OFS, 32'h0000_0002);
    chk(32'(flags_o[7]), 32'h0000_0001);
    do_reset();
    @(negedge clk_i);
    // failure flag gone; only the low alarm of the zero request is left
    chk(32'(flags_o), 32'h0000_0010);
    test_done();
  end
endmodule : tb_aoc_channel
